// ### design/stepper_ctrl.sv
`timescale 1ns/1ps
module stepper_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        thermal_cut,
  input  wire logic        undervoltage_cutoff_level,
  input  wire logic        electrical_fault_flag,
  input  wire logic        pump_fault_flag,
  input  wire logic        lost_step_flag,
  input  wire logic        switch_input_pin,
  input  wire logic        step_tick,
  output logic             bridge_hiz,
  output logic             hold_current,
  output logic             motor_clk_en,
  output logic             pump_en,
  output logic             accel_en,
  output logic [9:0]       speed_out,
  output logic             step_dir
);
  import stepper_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Sign-extend from the mode's width so positions wrap, never saturate
  function automatic logic [15:0] wrap_pos(input logic [15:0] p,
                                           input logic [1:0]  m);
    unique case (m)
      HALF:    wrap_pos = {{3{p[12]}}, p[12:0]};
      QUARTER: wrap_pos = {{2{p[13]}}, p[13:0]};
      EIGHTH:  wrap_pos = {p[14], p[14:0]};
      SIXTEEN: wrap_pos = p;
    endcase
  endfunction

  // Safe position in steps: one LSB is 4 half steps or 8/16/32 microsteps
  function automatic logic [15:0] safe_pos(input logic [10:0] s,
                                           input logic [1:0]  m);
    logic [15:0] ext;
    ext = {{5{s[10]}}, s};
    safe_pos = wrap_pos(16'(ext << (3'd2 + {1'b0, m})), m);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  run_state_t  run_ff;
  home_state_t home_ff;
  logic [15:0] target_position;
  logic [15:0] actual_position;
  logic [15:0] goal_ff;
  logic [1:0]  mode_ff;
  logic [10:0] sec_ff;
  logic [15:0] acc_ff;
  logic [9:0]  top_ff;
  logic [3:0]  floor_idx_ff;
  logic [15:0] first_goal;
  logic [15:0] second_goal;
  logic        halt_seen_ff;
  logic        switch_closed_flag;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        rvalid_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;

  logic        wr_go;
  logic        rd_go;
  logic        cause;
  logic        rd_stat1;
  logic        wr_target;
  logic        wr_cmd;
  logic [1:0]  cmd_code;
  logic        homing_on;
  logic        motion_goal_hit;
  logic [15:0] floor_speed;
  logic [19:0] acc_steps;
  logic        is_halt;
  logic        accept_cmd;

  // ----------------------------------------------------------------------
  // AXI4-Lite write and read channels
  // ----------------------------------------------------------------------
  // Address and data are taken together; a held response stalls both
  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign rd_go         = s_axi_arvalid & ~rvalid_ff;
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // Write response, one cycle after the handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (s_axi_awaddr[7:5] == 3'h0 && s_axi_awaddr[1:0] == 2'h0)
                   ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read data mux; the bus stays live in every run state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= RESP_OKAY;
      unique case (s_axi_araddr)
        TARGET_OFS: rdata_ff <= {16'h0000, target_position};
        ACTUAL_OFS: rdata_ff <= {16'h0000, actual_position};
        STATUS_OFS: rdata_ff <= {20'h00000, lost_step_flag, pump_fault_flag,
                                 electrical_fault_flag,
                                 undervoltage_cutoff_level, thermal_cut,
                                 home_ff, 1'b0, run_ff,
                                 switch_closed_flag};
        CFG_OFS:    rdata_ff <= {acc_ff, 1'b0, sec_ff, 2'b00, mode_ff};
        SPEED_OFS:  rdata_ff <= {6'h00, top_ff, 12'h000, floor_idx_ff};
        GOALS_OFS:  rdata_ff <= {second_goal, first_goal};
        ACCST_OFS:  rdata_ff <= {12'h000, acc_steps};
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= RESP_DECERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Side effects of accesses
  assign rd_stat1  = rd_go && s_axi_araddr == STATUS_OFS;
  assign wr_target = wr_go && s_axi_awaddr == TARGET_OFS;
  assign wr_cmd    = wr_go && s_axi_awaddr == CMD_OFS && s_axi_wstrb[0];
  assign cmd_code  = s_axi_wdata[1:0];
  assign is_halt   = wr_cmd && cmd_code == CMD_HALT;

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  // Acceleration may be rewritten at any time except while homing; keeping it still while
  // moving is left to software, as the ramp would otherwise jump.
  always_ff @(posedge aclk) begin
    logic [31:0] v;
    v = 32'h0000_0000;
    if (!aresetn) begin
      mode_ff      <= MODE_RST;
      sec_ff       <= SEC_RST;
      acc_ff       <= ACC_RST;
      top_ff       <= TOP_RST;
      floor_idx_ff <= 4'h0;
      first_goal   <= 16'h0000;
      second_goal  <= 16'h0000;
    end else if (wr_go && homing_on == 1'b0) begin
      unique case (s_axi_awaddr)
        CFG_OFS: begin
          v = merge({acc_ff, 1'b0, sec_ff, 2'b00, mode_ff},
                    s_axi_wdata, s_axi_wstrb);
          mode_ff <= v[CFG_MODE_LSB +: 2];
          sec_ff  <= v[CFG_SEC_LSB +: 11];
          acc_ff  <= v[CFG_ACC_LSB +: 16];
        end
        SPEED_OFS: begin
          v = merge({6'h00, top_ff, 12'h000, floor_idx_ff},
                    s_axi_wdata, s_axi_wstrb);
          top_ff       <= v[SPD_TOP_LSB +: 10];
          floor_idx_ff <= v[SPD_FLR_LSB +: 4];
        end
        GOALS_OFS: begin
          v = merge({second_goal, first_goal}, s_axi_wdata, s_axi_wstrb);
          first_goal  <= v[15:0];
          second_goal <= v[GOAL2_LSB +: 16];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Speed and acceleration arithmetic
  // ----------------------------------------------------------------------
  // Wide combinational divide; fine at a step rate far below the clock
  always_comb begin
    logic [19:0] top_sq;
    logic [19:0] flr_sq;
    logic [16:0] two_acc;
    top_sq  = 20'(top_ff * top_ff);
    floor_speed = (floor_idx_ff == 4'h0) ? {6'h00, top_ff}
                  : 16'(({6'h00, top_ff} * floor_idx_ff) >> 5);
    flr_sq  = 20'(floor_speed[9:0] * floor_speed[9:0]);
    two_acc = {acc_ff, 1'b0};
    acc_steps = (two_acc == 17'h0) ? 20'h00000
                : 20'((top_sq - flr_sq) / two_acc);
  end

  // ----------------------------------------------------------------------
  // Switch flag: mirrors the pin, triggers nothing else
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      switch_closed_flag <= 1'b0;
    end else begin
      switch_closed_flag <= switch_input_pin;
    end
  end

  // ----------------------------------------------------------------------
  // Run state: inactive, running, shutdown
  // ----------------------------------------------------------------------
  assign cause = thermal_cut | undervoltage_cutoff_level |
                 electrical_fault_flag | pump_fault_flag;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_ff <= M_INACTIVE;
    end else if (cause) begin
      run_ff <= M_SHUT;
    end else begin
      unique case (run_ff)
        M_INACTIVE: if (rd_stat1) run_ff <= M_RUN;
        M_SHUT:     if (rd_stat1) run_ff <= M_RUN;
        M_RUN:      ;
        default:    run_ff <= M_INACTIVE;
      endcase
    end
  end

  // Power stage follows the run state
  assign bridge_hiz   = run_ff != M_RUN;
  assign motor_clk_en = run_ff == M_RUN;
  assign pump_en      = run_ff == M_RUN;
  assign hold_current = run_ff == M_RUN && actual_position == goal_ff;

  // ----------------------------------------------------------------------
  // Homing sequencer
  // ----------------------------------------------------------------------
  assign homing_on       = home_ff != H_IDLE;
  assign motion_goal_hit = actual_position == goal_ff;
  assign accept_cmd      = wr_cmd && run_ff == M_RUN && !cause;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      home_ff      <= H_IDLE;
      halt_seen_ff <= 1'b0;
    end else if (run_ff != M_RUN || cause) begin
      home_ff      <= H_IDLE;
      halt_seen_ff <= 1'b0;
    end else begin
      unique case (home_ff)
        H_IDLE: if (accept_cmd && cmd_code == CMD_HOMING) begin
          // Equal goals would never finish a motion
          if (first_goal == actual_position || first_goal == second_goal)
            home_ff <= H_DEAD;
          else
            home_ff <= H_FIRST;
        end
        H_FIRST:  if (is_halt) home_ff <= H_IDLE;
                  else if (motion_goal_hit) home_ff <= H_SECOND;
        H_SECOND: if (is_halt) home_ff <= H_IDLE;
                  else if (motion_goal_hit)
                    home_ff <= (sec_ff == SEC_OFF) ? H_IDLE : H_SAFE;
        H_SAFE:   if (is_halt || motion_goal_hit) home_ff <= H_IDLE;
        H_DEAD: begin
          if (is_halt) halt_seen_ff <= 1'b1;
          if (halt_seen_ff && rd_stat1) begin
            home_ff      <= H_IDLE;
            halt_seen_ff <= 1'b0;
          end
        end
        default: home_ff <= H_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Positions, goal and stepping
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      target_position <= 16'h0000;
    end else if (cause && run_ff != M_SHUT) begin
      target_position <= actual_position;
    end else if (accept_cmd && !homing_on && is_halt) begin
      target_position <= actual_position;
    end else if (run_ff == M_RUN && !homing_on && !lost_step_flag) begin
      if (wr_target)
        target_position <= wrap_pos(16'(merge({16'h0000, target_position},
                             s_axi_wdata, s_axi_wstrb)), mode_ff);
      else if (accept_cmd && cmd_code == CMD_GO_SAFE && sec_ff != SEC_OFF)
        target_position <= safe_pos(sec_ff, mode_ff);
    end
  end

  // Active goal: homing goals while homing, actual position in deadlock, else the target register
  always_comb begin
    unique case (home_ff)
      H_FIRST:  goal_ff = wrap_pos(first_goal, mode_ff);
      H_SECOND: goal_ff = wrap_pos(second_goal, mode_ff);
      H_SAFE:   goal_ff = safe_pos(sec_ff, mode_ff);
      H_DEAD:   goal_ff = actual_position;
      default:  goal_ff = target_position;
    endcase
  end

  // Signed compare picks direction
  assign step_dir = $signed(goal_ff) > $signed(actual_position);
  assign accel_en = home_ff != H_SECOND;
  always_comb begin
    speed_out = (home_ff == H_SECOND) ? floor_speed[9:0] : top_ff;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      actual_position <= 16'h0000;
    end else if (home_ff == H_SECOND && motion_goal_hit &&
                 run_ff == M_RUN && !cause && !is_halt) begin
      actual_position <= 16'h0000;
    end else if (run_ff == M_RUN && step_tick && !motion_goal_hit) begin
      actual_position <= wrap_pos(step_dir ? actual_position + 16'h0001
                                  : actual_position - 16'h0001, mode_ff);
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_second_done;
    home_ff == H_SECOND && motion_goal_hit && run_ff == M_RUN && !cause &&
    !is_halt;
  endsequence

  a_fault_shutdown: assert property (@(posedge aclk) disable iff (!aresetn)
    cause |=> run_ff == M_SHUT && bridge_hiz)
    else $error("fault did not force shutdown");
  a_shut_copy: assert property (@(posedge aclk) disable iff (!aresetn)
    cause && run_ff != M_SHUT |=> target_position == $past(actual_position))
    else $error("target not loaded from actual");
  a_shut_exit: assert property (@(posedge aclk) disable iff (!aresetn)
    run_ff == M_SHUT && !rd_stat1 ##1 !cause |-> run_ff == M_SHUT)
    else $error("shutdown left without status read");
  a_wake_power: assert property (@(posedge aclk) disable iff (!aresetn)
    run_ff == M_SHUT && rd_stat1 && !cause |=> pump_en && motor_clk_en)
    else $error("power not restored on exit");
  a_switch_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    !switch_input_pin |=> !switch_closed_flag)
    else $error("switch flag set while open");
  a_lost_step: assert property (@(posedge aclk) disable iff (!aresetn)
    lost_step_flag && !cause && wr_target |=> $stable(target_position))
    else $error("target changed under lost step");
  a_home_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_second_done |=> actual_position == 16'h0000 &&
                      home_ff == (sec_ff == SEC_OFF ? H_IDLE : H_SAFE))
    else $error("homing end did not zero position");
  a_dead_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    home_ff == H_DEAD && !halt_seen_ff && !cause && run_ff == M_RUN
    && !is_halt |=> home_ff == H_DEAD)
    else $error("deadlock left without halt");
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go |=> rvalid_ff ##0 (rvalid_ff && !s_axi_rready)[*1] |=> rvalid_ff)
    else $error("read answer dropped");

endmodule

// ### design/stepper_pkg.sv
package stepper_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] TARGET_OFS = 8'h00; // W target-set, R target
  localparam logic [7:0] ACTUAL_OFS = 8'h04; // R actual, status read two
  localparam logic [7:0] STATUS_OFS = 8'h08; // R flags, status read one
  localparam logic [7:0] CMD_OFS    = 8'h0C; // W command code
  localparam logic [7:0] CFG_OFS    = 8'h10; // mode, safe pos, acc
  localparam logic [7:0] SPEED_OFS  = 8'h14; // top speed, floor index
  localparam logic [7:0] GOALS_OFS  = 8'h18; // first and second goal
  localparam logic [7:0] ACCST_OFS  = 8'h1C; // R acceleration steps

  // Command codes written to CMD_OFS bits [1:0]
  localparam logic [1:0] CMD_GO_SAFE = 2'h1;
  localparam logic [1:0] CMD_HOMING  = 2'h2;
  localparam logic [1:0] CMD_HALT    = 2'h3;

  // Field positions
  localparam int CFG_MODE_LSB = 0;   // [1:0] stepping mode
  localparam int CFG_ACC_LSB  = 16;  // [31:16] acceleration value
  localparam int CFG_SEC_LSB  = 4;   // [14:4] safe position, 11 bits
  localparam int SPD_TOP_LSB  = 16;  // [25:16] top speed
  localparam int SPD_FLR_LSB  = 0;   // [3:0] floor index
  localparam int GOAL2_LSB    = 16;

  // Reset values
  localparam logic [1:0]  MODE_RST = 2'h0;
  localparam logic [10:0] SEC_RST  = 11'h400; // -1024, safe move disabled
  localparam logic [15:0] ACC_RST  = 16'h0031;
  localparam logic [9:0]  TOP_RST  = 10'h063;
  localparam logic [10:0] SEC_OFF  = 11'h400;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    HALF    = 2'b00,
    QUARTER = 2'b01,
    EIGHTH  = 2'b10,
    SIXTEEN = 2'b11
  } step_mode_t;

  typedef enum logic [1:0] {
    M_INACTIVE = 2'b00,
    M_RUN      = 2'b01,
    M_SHUT     = 2'b10
  } run_state_t;

  typedef enum logic [2:0] {
    H_IDLE   = 3'b000,
    H_FIRST  = 3'b001,
    H_SECOND = 3'b010,
    H_SAFE   = 3'b011,
    H_DEAD   = 3'b100
  } home_state_t;

endpackage

// ### dv/stepper_motor_model.sv
`timescale 1ns/1ps
// Motor side: turns a burst request into single-cycle step pulses
module stepper_motor_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       motor_clk_en,
  input  wire logic       start,
  input  wire logic [7:0] len,
  output logic            step_tick,
  output logic            busy
);
  logic [7:0] left_ff;
  logic       tick_ff;

  // A gap after every pulse keeps each tick a separate step; a stopped
  // motor clock freezes the burst instead of dropping it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_ff <= 8'h00;
      tick_ff <= 1'b0;
    end else if (start) begin
      left_ff <= len;
      tick_ff <= 1'b0;
    end else if (motor_clk_en && left_ff != 8'h00 && !tick_ff) begin
      left_ff <= left_ff - 8'h01;
      tick_ff <= 1'b1;
    end else begin
      tick_ff <= 1'b0;
    end
  end
  assign step_tick = tick_ff;
  assign busy      = (left_ff != 8'h00) || tick_ff; // Burst still running
endmodule

// ### dv/stepper_position_shutdown_homing_tb_top.sv
`timescale 1ns/1ps
module stepper_position_shutdown_homing_tb_top;
  import stepper_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, lost, sw, tick;
  logic        hiz, hold, mclk, pump, acc_en, dir, start, busy;
  logic [7:0]  awaddr, araddr, len;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs, bs;
  logic [3:0]  cause;
  logic [9:0]  speed;
  logic [15:0] pos;
  int          n_mismatch, checks;

  // Write strobes stay full: every register is written as a whole word
  stepper_ctrl i_stepper_ctrl (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .thermal_cut(cause[0]),
    .undervoltage_cutoff_level(cause[1]), .electrical_fault_flag(cause[2]),
    .pump_fault_flag(cause[3]), .lost_step_flag(lost),
    .switch_input_pin(sw), .step_tick(tick), .bridge_hiz(hiz),
    .hold_current(hold), .motor_clk_en(mclk), .pump_en(pump),
    .accel_en(acc_en), .speed_out(speed), .step_dir(dir));
  stepper_motor_model i_stepper_motor_model (
    .aclk(aclk), .aresetn(aresetn), .motor_clk_en(mclk), .start(start),
    .len(len), .step_tick(tick), .busy(busy));

  // 125 MHz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ready is combinational, so it is judged at the falling edge and the
  // transfer completes on the rising edge that follows
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'b111;
    do @(negedge aclk); while (awready !== 1'b1);
    @(posedge aclk);
    {awvalid, wvalid} <= 2'b00;
    do @(negedge aclk); while (bvalid !== 1'b1);
    @(posedge aclk);
    bs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    @(posedge aclk);
    {rs, rd} = {rresp, rdata};
    rready <= 1'b0;
  endtask

  task automatic steps(input logic [7:0] n);
    @(posedge aclk);
    {start, len} <= {1'b1, n};
    @(posedge aclk);
    start <= 1'b0;
    do @(negedge aclk); while (busy);
    repeat (3) @(posedge aclk);
  endtask

  task automatic report_and_stop();
    if (n_mismatch == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, start, lost, sw} = '0;
    {aresetn, awaddr, araddr, wdata, len, cause} = '0;
    n_mismatch = 0;
    checks = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("inactive", {hiz, pump}, 2'b10);
    rd_reg(STATUS_OFS);
    rd_reg(STATUS_OFS);
    chk("awake", rd[3:1], 3'd1);
    wr(SPEED_OFS, 32'h0064_0000);
    rd_reg(ACCST_OFS);
    chk("acc_floor0", rd, 32'h0);
    wr(SPEED_OFS, 32'h0064_0008);
    rd_reg(ACCST_OFS);
    chk("acc_steps", rd, 32'h0000_005F);
    wr(TARGET_OFS, 32'h0000_1005);
    rd_reg(TARGET_OFS);
    chk("target_wrap", rd[15:0], 16'hF005);
    wr(TARGET_OFS, 32'h0000_0005);
    steps(8'd5);
    rd_reg(ACTUAL_OFS);
    chk("actual", {hold, rd[15:0]}, 17'h1_0005);
    // Safe position 2 in half steps means 8 steps
    wr(CFG_OFS, 32'h0005_0020);
    lost <= 1'b1;
    wr(TARGET_OFS, 32'h0000_0009);
    wr(CMD_OFS, {30'h0, CMD_GO_SAFE});
    rd_reg(TARGET_OFS);
    chk("target_locked", rd[15:0], 16'h0005);
    lost <= 1'b0;
    wr(CMD_OFS, {30'h0, CMD_GO_SAFE});
    rd_reg(TARGET_OFS);
    chk("safe_target", rd[15:0], 16'h0008);
    steps(8'd3);
    wr(CFG_OFS, 32'h0005_4000);
    rd_reg(STATUS_OFS);
    chk("switch_open", rd[0], 1'b0);
    sw <= 1'b1;
    repeat (4) @(posedge aclk);
    rd_reg(STATUS_OFS);
    chk("switch_closed", rd[0], 1'b1);
    rd_reg(TARGET_OFS);
    chk("no_latch", rd[15:0], 16'h0008);
    // Each shutdown cause in turn, caught in mid-move
    pos = 16'd8;
    for (int i = 0; i < 4; i++) begin
      wr(TARGET_OFS, {16'h0, pos + 16'd4});
      steps(8'd2);
      cause[i] <= 1'b1;
      repeat (2) @(posedge aclk);
      chk("shut", {hiz, pump, mclk}, 3'b100);
      rd_reg(TARGET_OFS);
      chk("target_copy", rd[15:0], pos + 16'd2);
      cause[i] <= 1'b0;
      repeat (2) @(posedge aclk);
      chk("still_shut", hiz, 1'b1);
      rd_reg(STATUS_OFS);
      repeat (2) @(posedge aclk);
      chk("resume", {hiz, pump, mclk, hold}, 4'b0111);
      pos = pos + 16'd2;
    end
    // Homing from 16: first goal 20, second goal 18
    wr(GOALS_OFS, 32'h0012_0014);
    wr(CMD_OFS, {30'h0, CMD_HOMING});
    repeat (2) @(posedge aclk);
    chk("first_move", {acc_en, dir, speed}, {2'b11, 10'd100});
    wr(SPEED_OFS, 32'h0064_0000);
    steps(8'd4);
    rd_reg(STATUS_OFS);
    chk("second_state", rd[6:4], 3'd2);
    chk("second_move", {acc_en, dir, speed}, {2'b00, 10'd25});
    steps(8'd2);
    rd_reg(ACTUAL_OFS);
    chk("homed_zero", rd[15:0], 16'h0000);
    rd_reg(STATUS_OFS);
    chk("homing_done", rd[6:4], 3'd0);
    wr(GOALS_OFS, 32'h0003_0000);
    wr(CMD_OFS, {30'h0, CMD_HOMING});
    rd_reg(STATUS_OFS);
    chk("deadlock", rd[6:4], 3'd4);
    wr(CMD_OFS, {30'h0, CMD_HALT});
    rd_reg(STATUS_OFS);
    rd_reg(STATUS_OFS);
    chk("unlocked", rd[6:4], 3'd0);
    // Quarter steps wrap at 14 bits; a sixteenth safe LSB is 32 steps
    wr(CFG_OFS, 32'h0005_0021);
    wr(TARGET_OFS, 32'h0000_2005);
    rd_reg(TARGET_OFS);
    chk("quarter_wrap", rd[15:0], 16'hE005);
    wr(CFG_OFS, 32'h0005_0023);
    wr(CMD_OFS, {30'h0, CMD_GO_SAFE});
    rd_reg(TARGET_OFS);
    chk("safe_sixteenth", rd[15:0], 16'h0040);
    rd_reg(8'h20);
    chk("unmapped", {30'h0, rs}, {30'h0, RESP_DECERR});
    wr(8'h20, 32'h0000_0000);
    chk("unmapped_wr", {30'h0, bs}, {30'h0, RESP_DECERR});
    report_and_stop();
  end

  // Watchdog, well past the few hundred cycles the sequence needs
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
